// ===== core/tpq_pkg.sv
// Purpose: constants and types of the transmit pending-queue reader
// Assumes: one 100 MHz clock, classic wishbone register access
// Notes:   register offsets are byte addresses, registers sit in low 16 bits
//
// Contract
// [RULE1] low sixteen entry bits index the first descriptor of a chain
// [RULE2] channel field at bit 16: zero means channel one, all ones channel 256
// [RULE3] priority flag at bit 24 sends chain right after the current packet
// [RULE4] reactivate flag at bit 25 sets channel enable, otherwise unchanged
// [RULE5] host sets reactivate only in first entry after an error
// [RULE6] bits 26 to 31 of a pending entry are ignored
// [RULE7] engine alone moves read pointer, host alone moves write pointer; host can still write the read pointer while stopped
// [RULE8] queue is empty when read pointer equals write pointer
// [RULE9] host treats queue full when read leads write by one, one slot spare
// [RULE10] fetch at base plus read pointer, advance, wrap to zero past end
// [RULE11] no fetch before the transmit master enable is set
// [RULE12] every fetch sets the pending-read status flag
// [RULE13] prefetch FIFO holds sixteen one-dword entries
// [RULE14] control bit 0 selects burst fetch, zero selects single fetch
// [RULE15] burst refill only once FIFO drained, checking write pointer first
// [RULE16] burst fetches what fits, or only what is queued
// [RULE17] nothing queued means wait and retry; burst end advances and flags
// [RULE18] flush bit 1 discards FIFO contents; software clears it again
// [RULE19] control also holds done enable, done flush, done threshold 8..10
// [RULE20] done entries posted per chain or per buffer by channel selection
// [RULE21] end register is an index relative to the base
// [RULE22] base address held as lower and upper word registers
// [RULE23] transmit error clears channel enable and sends an abort
// [RULE24] at most two chains held per channel, rest linked in memory
// [RULE25] pointers and end share dword index units
`default_nettype none

package tpq_pkg;

   // -----------------------------------------------------------------
   // register map, byte addresses
   // -----------------------------------------------------------------
   localparam int unsigned AW_REG        = 12;
   localparam logic [11:0] A_BASE_LO     = 12'h800;
   localparam logic [11:0] A_BASE_HI     = 12'h804;
   localparam logic [11:0] A_END         = 12'h808;
   localparam logic [11:0] A_WPTR        = 12'h80C;
   localparam logic [11:0] A_RPTR        = 12'h810;
   localparam logic [11:0] A_QCTL        = 12'h880;
   localparam logic [11:0] A_MCTL        = 12'h8C0;
   localparam logic [11:0] A_STAT        = 12'h8C4;

   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int unsigned QC_PBURST     = 0;
   localparam int unsigned QC_PFLUSH     = 1;
   localparam int unsigned QC_DBURST     = 2;
   localparam int unsigned QC_DFLUSH     = 3;
   localparam int unsigned QC_THR_LO     = 8;
   localparam int unsigned MC_TXEN       = 0;
   localparam int unsigned ST_PREAD      = 0;
   localparam logic [15:0] QCTL_RST      = 16'h0000;
   localparam logic [15:0] PTR_RST       = 16'h0000;
   localparam logic [15:0] QCTL_MASK     = 16'h070F;
   localparam int unsigned FIFO_DEPTH    = 16;
   localparam int unsigned NUM_CHAN      = 256;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic {TPQ_IDLE, TPQ_FETCH} tpq_fsm_t;

   // one pending-queue entry as it lies in memory
   typedef struct packed {
      logic [2:0]  spare;
      logic [2:0]  status;
      logic        channel_reactivate_flag;
      logic        priority_flag;
      logic [7:0]  chan;
      logic [15:0] desc_idx;
   } tpq_entry_t;

   // wishbone classic master request
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } tpq_wb_req_t;

endpackage : tpq_pkg

`default_nettype wire

// ===== core/tpq_reader.sv
// Purpose: transmit pending-queue reader with prefetch FIFO
// Assumes: memory read port answers each held request with a one-cycle ack
// Notes:   channel enables live here; abort and done posting are pulses
//
// Our own choice: the Wishbone register port.
`default_nettype none

module tpq_reader
   import tpq_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic              mclk_i,
   input  wire logic              reset_i,
   // register bus
   input  wire tpq_wb_req_t       wb_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   // memory read port
   output logic                   mem_req_o,
   output logic [31:0]            mem_addr_o,
   input  wire logic              mem_ack_i,
   input  wire logic [31:0]       mem_rdata_i,
   // entry stream to the scheduler
   output logic                   ent_valid_o,
   output tpq_entry_t             ent_o,
   output logic                   ent_priority_o,
   input  wire logic              ent_ready_i,
   // transmit errors and aborts
   input  wire logic              tx_err_i,
   input  wire logic [7:0]        tx_err_chan_i,
   output logic                   abort_o,
   output logic [7:0]             abort_chan_o,
   // done posting
   input  wire logic              chain_done_i,
   input  wire logic              buffer_done_i,
   input  wire logic              done_sel_i,
   output logic                   done_post_o,
   // status and config
   output logic [NUM_CHAN-1:0]    chan_enable_o,
   output logic                   pending_read_flag_o,
   output logic                   done_burst_enable_o,
   output logic                   done_fifo_flush_o,
   output logic [2:0]             done_threshold_o
);

   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [15:0]                base_lo;
      logic [15:0]                base_hi;
      logic [15:0]                qend;
      logic [15:0]                wptr;
      logic [15:0]                rptr;
      logic [15:0]                qctl;
      logic                       tx_en;
      logic                       pread;
      logic [NUM_CHAN-1:0]        chan_en;
      logic [DEPTH-1:0][31:0]     fifo;
      logic [AW:0]                cnt;
      logic [AW-1:0]              head;
      logic [AW-1:0]              tail;
      logic [AW:0]                left;
      tpq_fsm_t                   st;
      logic                       burst;
      logic [31:0]                maddr;
      logic                       ack;
      logic [31:0]                rdat;
      logic                       abort;
      logic [7:0]                 abort_ch;
      logic                       dpost;
   } tpq_state_t;

   tpq_state_t state_ff;
   tpq_state_t nxt_state;

   logic        wb_req;
   logic        pop;
   logic        push;
   logic        flush;
   logic [16:0] avail;
   logic [16:0] qsize;
   logic [15:0] rp_inc;
   logic [15:0] rp_next;
   logic [31:0] base;
   tpq_entry_t  head_ent;

   // byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         r[15:8] = dat[15:8];
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // pointers count dwords, same units as the end index
   assign base    = {state_ff.base_hi, state_ff.base_lo};          // RULE22
   assign rp_inc  = state_ff.rptr + 16'h0001;
   assign rp_next = (rp_inc > state_ff.qend) ? PTR_RST : rp_inc;    // RULE10 RULE21
   assign qsize   = {1'b0, state_ff.qend} + 17'h00001;              // RULE25
   assign flush   = state_ff.qctl[QC_PFLUSH];
   assign wb_req  = wb_i.cyc && wb_i.stb && !state_ff.ack;
   assign pop     = (state_ff.cnt != '0) && ent_ready_i && !flush;
   assign push    = (state_ff.st == TPQ_FETCH) && mem_ack_i;
   assign head_ent = tpq_entry_t'(state_ff.fifo[state_ff.head]);

   // entries queued in memory; equal pointers mean empty
   always_comb begin
      if (state_ff.wptr == state_ff.rptr) begin
         avail = 17'h00000;                                         // RULE8
      end else if (state_ff.wptr > state_ff.rptr) begin
         avail = {1'b0, state_ff.wptr} - {1'b0, state_ff.rptr};
      end else begin
         avail = qsize - {1'b0, state_ff.rptr} + {1'b0, state_ff.wptr};
      end
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      nxt_state       = state_ff;
      nxt_state.ack   = 1'b0;
      nxt_state.abort = 1'b0;
      nxt_state.dpost = 1'b0;

      // register bus: one-cycle registered ack, unmapped reads zero
      if (wb_req) begin
         nxt_state.ack  = 1'b1;
         nxt_state.rdat = 32'h0000_0000;
         case (wb_i.adr)
            A_BASE_LO: nxt_state.rdat[15:0] = state_ff.base_lo;
            A_BASE_HI: nxt_state.rdat[15:0] = state_ff.base_hi;
            A_END:     nxt_state.rdat[15:0] = state_ff.qend;
            A_WPTR:    nxt_state.rdat[15:0] = state_ff.wptr;
            A_RPTR:    nxt_state.rdat[15:0] = state_ff.rptr;
            A_QCTL:    nxt_state.rdat[15:0] = state_ff.qctl;
            A_MCTL:    nxt_state.rdat[MC_TXEN] = state_ff.tx_en;
            A_STAT:    nxt_state.rdat[ST_PREAD] = state_ff.pread;
            default:   nxt_state.rdat = 32'h0000_0000;
         endcase
         if (wb_i.we) begin
            case (wb_i.adr)
               A_BASE_LO: nxt_state.base_lo = merge16(state_ff.base_lo, wb_i.dat, wb_i.sel);
               A_BASE_HI: nxt_state.base_hi = merge16(state_ff.base_hi, wb_i.dat, wb_i.sel);
               A_END:     nxt_state.qend = merge16(state_ff.qend, wb_i.dat, wb_i.sel);
               A_WPTR:    nxt_state.wptr = merge16(state_ff.wptr, wb_i.dat, wb_i.sel);
               A_RPTR: begin
                  // host may seed it only while the engine is stopped
                  if (!state_ff.tx_en) begin                        // RULE7
                     nxt_state.rptr = merge16(state_ff.rptr, wb_i.dat, wb_i.sel);
                  end
               end
               A_QCTL: begin                                        // RULE19
                  nxt_state.qctl = merge16(state_ff.qctl, wb_i.dat, wb_i.sel) & QCTL_MASK;
               end
               A_MCTL: begin
                  if (wb_i.sel[0]) begin
                     nxt_state.tx_en = wb_i.dat[MC_TXEN];
                  end
               end
               A_STAT: begin
                  // write one to clear
                  if (wb_i.sel[0] && wb_i.dat[ST_PREAD]) begin
                     nxt_state.pread = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end

      // fetch engine
      case (state_ff.st)
         TPQ_IDLE: begin
            // burst waits for a drained FIFO; single keeps one entry
            if (state_ff.tx_en && !flush && state_ff.cnt == '0      // RULE11 RULE15
                && avail != 17'h00000) begin                        // RULE17
               nxt_state.burst = state_ff.qctl[QC_PBURST];          // RULE14
               if (!state_ff.qctl[QC_PBURST]) begin
                  nxt_state.left = (AW+1)'(1);
               end else if (avail >= 17'(DEPTH)) begin               // RULE16
                  nxt_state.left = DEPTH_W;
               end else begin
                  nxt_state.left = avail[AW:0];
               end
               nxt_state.maddr = base + {14'h0000, state_ff.rptr, 2'b00}; // RULE10
               nxt_state.st    = TPQ_FETCH;
            end
         end
         TPQ_FETCH: begin
            if (mem_ack_i) begin
               nxt_state.rptr  = rp_next;                           // RULE10
               nxt_state.maddr = base + {14'h0000, rp_next, 2'b00};
               nxt_state.left  = state_ff.left - (AW+1)'(1);
               if (!state_ff.burst || state_ff.left == (AW+1)'(1)) begin
                  nxt_state.pread = 1'b1;                           // RULE12 RULE17
               end
               if (state_ff.left == (AW+1)'(1)) begin
                  nxt_state.st = TPQ_IDLE;
               end
            end
         end
         default: nxt_state.st = TPQ_IDLE;
      endcase

      // FIFO push and pop; a word landing during flush is dropped
      if (push && !flush) begin
         nxt_state.fifo[state_ff.tail] = mem_rdata_i;               // RULE13
         nxt_state.tail = state_ff.tail + AW'(1);
      end
      if (pop) begin
         nxt_state.head = state_ff.head + AW'(1);
      end
      nxt_state.cnt = state_ff.cnt + (AW+1)'(push && !flush) - (AW+1)'(pop);
      if (flush) begin                                              // RULE18
         nxt_state.cnt  = '0;
         nxt_state.head = '0;
         nxt_state.tail = '0;
      end

      // error takes channel out of service and sends an abort
      if (tx_err_i) begin
         nxt_state.chan_en[tx_err_chan_i] = 1'b0;                   // RULE23
         nxt_state.abort    = 1'b1;
         nxt_state.abort_ch = tx_err_chan_i;
      end
      // reactivation on an accepted entry wins over a same-cycle error
      if (pop && head_ent.channel_reactivate_flag) begin            // RULE4 RULE5
         nxt_state.chan_en[head_ent.chan] = 1'b1;
      end

      // done entry per chain or per buffer
      nxt_state.dpost = done_sel_i ? buffer_done_i : chain_done_i;  // RULE20
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff       <= '0;
         state_ff.qctl  <= QCTL_RST;
         state_ff.rptr  <= PTR_RST;
         state_ff.wptr  <= PTR_RST;
         state_ff.st    <= TPQ_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // the scheduler holds two chains per channel and links the rest
   assign wb_ack_o             = state_ff.ack;
   assign wb_dat_o             = state_ff.rdat;
   assign mem_req_o            = (state_ff.st == TPQ_FETCH);
   assign mem_addr_o           = state_ff.maddr;
   assign ent_valid_o          = (state_ff.cnt != '0) && !flush;    // RULE24
   assign ent_o.spare          = 3'h0;                              // RULE6
   assign ent_o.status         = 3'h0;
   assign ent_o.channel_reactivate_flag = head_ent.channel_reactivate_flag;
   assign ent_o.priority_flag  = head_ent.priority_flag;
   assign ent_o.chan           = head_ent.chan;                     // RULE2
   assign ent_o.desc_idx       = head_ent.desc_idx;                 // RULE1
   assign ent_priority_o       = head_ent.priority_flag;            // RULE3
   assign abort_o              = state_ff.abort;
   assign abort_chan_o         = state_ff.abort_ch;
   assign done_post_o          = state_ff.dpost;
   assign chan_enable_o        = state_ff.chan_en;
   assign pending_read_flag_o  = state_ff.pread;
   assign done_burst_enable_o  = state_ff.qctl[QC_DBURST];
   assign done_fifo_flush_o    = state_ff.qctl[QC_DFLUSH];
   assign done_threshold_o     = state_ff.qctl[QC_THR_LO +: 3];

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held longer than one cycle");
   // a burst already under way may finish after the enable drops
   a_fetch_needs_enable: assert property ($rose(mem_req_o) |-> $past(state_ff.tx_en)) // RULE11
      else $error("fetch started while transmit disabled");
   a_rptr_wraps_zero: assert property (push && state_ff.rptr >= state_ff.qend // RULE10
      |=> state_ff.rptr == PTR_RST)
      else $error("read pointer failed to wrap");
   a_burst_starts_empty: assert property ($rose(mem_req_o) && state_ff.burst // RULE15
      |-> state_ff.cnt == '0)
      else $error("burst refill with FIFO not drained");
   a_fifo_never_over: assert property (state_ff.cnt <= DEPTH_W)     // RULE13
      else $error("prefetch FIFO overfilled");
   a_flush_discards: assert property (flush |=> !ent_valid_o && state_ff.cnt == '0) // RULE18
      else $error("flush left entries");
   a_reactivate_sets: assert property (pop && head_ent.channel_reactivate_flag // RULE4
      |=> chan_enable_o[$past(head_ent.chan)])
      else $error("reactivation did not enable channel");
   a_single_flags: assert property (push && !state_ff.burst         // RULE12
      |=> pending_read_flag_o)
      else $error("fetch did not set pending-read flag");
   a_empty_no_fetch: assert property (state_ff.st == TPQ_IDLE       // RULE8
      && state_ff.wptr == state_ff.rptr |=> !mem_req_o)
      else $error("fetch from empty queue");
   a_error_aborts: assert property (tx_err_i && !(pop && head_ent.chan == tx_err_chan_i) // RULE23
      |=> abort_o && !chan_enable_o[abort_chan_o])
      else $error("error did not abort and disable");
   a_status_ignored: assert property (ent_valid_o |-> ent_o.status == 3'h0) // RULE6
      else $error("status bits passed through");

   c_burst_fill: cover property (push && state_ff.burst && state_ff.left == DEPTH_W);
   c_flush_full: cover property (flush && state_ff.cnt != '0);
   c_reactivate: cover property (pop && head_ent.channel_reactivate_flag);

endmodule : tpq_reader

`default_nettype wire

// ===== verif/tpq_mem_model.sv
// Purpose: host memory holding the pending queue, answers reader fetches
// Assumes: queue of eight dwords at an address aligned to 32 bytes
// Notes:   answer delay varies 0..2 cycles so bursts see stalls
`default_nettype none

module tpq_mem_model (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // memory read port
   input  wire logic        mem_req_i,
   input  wire logic [31:0] mem_addr_i,
   output logic             mem_ack_o,
   output logic [31:0]      mem_rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // queue storage, filled by the bench
   // ------------------------------------------------------------
   logic [31:0] mem [0:7];
   int unsigned wait_n;

   // one-cycle ack per word; data toggles when idle so stale data never looks valid
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= 32'h0;
         wait_n      <= 0;
      end else if (mem_ack_o) begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         wait_n      <= $urandom_range(0, 2);
      end else if (mem_req_i && wait_n == 0) begin
         mem_ack_o   <= 1'b1;
         mem_rdata_o <= mem[mem_addr_i[4:2]];
      end else begin
         if (wait_n != 0) wait_n <= wait_n - 1;
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule // tpq_mem_model

`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench of the pending-queue reader
// Assumes: queue base 0x1000, end index 7, so eight slots
// Notes:   reads and popped entries are checked against queued notes
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import tpq_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic mclk_i, reset_i, mem_req_o, mem_ack_i, ent_valid_o, ent_priority_o, ent_ready_i;
   logic wb_ack_o, tx_err_i, abort_o, chain_done_i, buffer_done_i, done_sel_i, done_post_o;
   logic pending_read_flag_o, done_burst_enable_o, done_fifo_flush_o;
   logic [31:0] wb_dat_o, mem_addr_o, mem_rdata_i, rdat, dp_exp;
   logic [7:0] tx_err_chan_i, abort_chan_o;
   logic [2:0] done_threshold_o;
   logic [NUM_CHAN-1:0] chan_enable_o;
   logic rd_chk, rdy_en, mem_seen, dp_ok;
   tpq_wb_req_t wb_i;
   tpq_entry_t  ent_o;
   logic [31:0] exp_rd[$], exp_ent[$];
   int n_errors, check_count, cur;

   tpq_reader uut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .ent_valid_o(ent_valid_o),
      .ent_o(ent_o), .ent_priority_o(ent_priority_o), .ent_ready_i(ent_ready_i),
      .tx_err_i(tx_err_i), .tx_err_chan_i(tx_err_chan_i), .abort_o(abort_o),
      .abort_chan_o(abort_chan_o), .chain_done_i(chain_done_i),
      .buffer_done_i(buffer_done_i), .done_sel_i(done_sel_i), .done_post_o(done_post_o),
      .chan_enable_o(chan_enable_o), .pending_read_flag_o(pending_read_flag_o),
      .done_burst_enable_o(done_burst_enable_o), .done_fifo_flush_o(done_fifo_flush_o),
      .done_threshold_o(done_threshold_o));
   tpq_mem_model mdl (.mclk_i(mclk_i), .reset_i(reset_i), .mem_req_i(mem_req_o),
      .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // classic cycle: hold until ack, release at that edge
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic chk, input logic [31:0] e);
      int n;
      n = 0;
      if (chk) exp_rd.push_back(e);
      @(posedge mclk_i);
      wb_i   <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
      rd_chk <= chk;
      do begin @(posedge mclk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      rdat = wb_dat_o;
      wb_i.cyc <= 1'b0;
      wb_i.stb <= 1'b0;
      rd_chk   <= 1'b0;
   endtask
   task automatic wait_rptr(input int t);
      int n;
      n = 0;
      do begin wb(1'b0, A_RPTR, 32'h0, 1'b0, 32'h0); n++; end while (rdat != t && n < 100);
      check(rdat, t);
   endtask
   // entries the reader should hand out, status and spare bits ignored
   task automatic push_to(input int t);
      while (cur != t) begin
         exp_ent.push_back(mdl.mem[cur] & 32'h03FF_FFFF);
         cur = (cur + 1) % 8;
      end
   endtask

   // clock, watchdog and random side inputs
   initial begin mclk_i = 1'b0; forever #5 mclk_i = ~mclk_i; end
   initial begin #300us; n_errors++; stop_test(); end
   always @(posedge mclk_i) begin
      chain_done_i  <= 1'($urandom_range(0, 1));
      buffer_done_i <= 1'($urandom_range(0, 1));
      done_sel_i    <= 1'($urandom_range(0, 1));
      ent_ready_i   <= rdy_en & 1'($urandom_range(0, 1));
   end

   // monitor: takes the oldest note whenever a result shows
   always @(posedge mclk_i) if (!reset_i) begin
      if (mem_req_o) mem_seen <= 1'b1;
      if (mem_req_o) check(mem_addr_o & 32'hFFFF_FFE3, 32'h0000_1000);
      if (wb_ack_o && rd_chk) check(wb_dat_o, exp_rd.pop_front());
      if (ent_valid_o && ent_ready_i) begin
         check(ent_o, exp_ent.size() ? exp_ent[0] : ~ent_o);
         check(ent_priority_o, exp_ent.size() ? exp_ent[0][24] : 1'bx);
         if (exp_ent.size()) void'(exp_ent.pop_front());
      end
      if (dp_ok) check(done_post_o, dp_exp);
      dp_exp <= done_sel_i ? buffer_done_i : chain_done_i;
      dp_ok  <= 1'b1;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int n;
      {reset_i, rd_chk, rdy_en, mem_seen, dp_ok} = 5'b10100;
      {tx_err_i, tx_err_chan_i, chain_done_i, buffer_done_i, done_sel_i} = '0;
      {wb_i, ent_ready_i, dp_exp} = '0;
      n_errors = 0; check_count = 0; cur = 0;
      void'($urandom(32'h854F8573));
      for (int i = 0; i < 8; i++) mdl.mem[i] = $urandom() & 32'hFDFF_FFFF;
      mdl.mem[3][25:16] = 10'h205;
      mdl.mem[4][24:16] = 9'h1FF;
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      // reset values, unmapped place, control mask
      wb(1'b0, A_QCTL, 0, 1'b1, 32'h0);
      wb(1'b0, A_RPTR, 0, 1'b1, 32'h0);
      wb(1'b0, 12'h900, 0, 1'b1, 32'h0);
      wb(1'b1, A_QCTL, 32'hFFFF, 1'b0, 0);
      check({done_threshold_o, done_fifo_flush_o, done_burst_enable_o}, 5'h1F);
      wb(1'b0, A_QCTL, 0, 1'b1, 32'h070F);
      wb(1'b1, A_QCTL, 32'h0, 1'b0, 0);
      check({done_threshold_o, done_fifo_flush_o, done_burst_enable_o}, 5'h00);
      $display("test registers done");
      // queue set up, nothing fetched while the master enable is off
      wb(1'b1, A_BASE_LO, 32'h1000, 1'b0, 0);
      wb(1'b1, A_BASE_HI, 32'h0, 1'b0, 0);
      wb(1'b0, A_BASE_LO, 0, 1'b1, 32'h1000);
      wb(1'b1, A_END, 32'h7, 1'b0, 0);
      wb(1'b1, A_WPTR, 32'h3, 1'b0, 0);
      repeat (20) @(posedge mclk_i);
      check(mem_seen, 1'b0);
      $display("test idle done");
      // single fetches, status flag set and cleared
      push_to(3);
      wb(1'b1, A_MCTL, 32'h1, 1'b0, 0);
      wait_rptr(3);
      check(pending_read_flag_o, 1'b1);
      // read pointer belongs to the engine while it runs
      wb(1'b1, A_RPTR, 32'h6, 1'b0, 0);
      wb(1'b0, A_RPTR, 0, 1'b1, 32'h3);
      wb(1'b0, A_STAT, 0, 1'b1, 32'h1);
      wb(1'b1, A_STAT, 32'h1, 1'b0, 0);
      check(pending_read_flag_o, 1'b0);
      wb(1'b0, A_STAT, 0, 1'b1, 32'h0);
      $display("test single done");
      // burst across the wrap, queue filled to full with one slot spare
      wb(1'b1, A_QCTL, 32'h1, 1'b0, 0);
      push_to(2);
      wb(1'b1, A_WPTR, 32'h2, 1'b0, 0);
      wait_rptr(2);
      wb(1'b0, A_STAT, 0, 1'b1, 32'h1);
      n = 0;
      while (exp_ent.size() != 0 && n < 500) begin @(posedge mclk_i); n++; end
      check(exp_ent.size(), 0);
      check(chan_enable_o[5], 1'b1);
      mem_seen <= 1'b0;
      repeat (20) @(posedge mclk_i);
      check(mem_seen, 1'b0);
      $display("test burst done");
      // flush with the consumer stalled
      rdy_en <= 1'b0;
      wb(1'b1, A_WPTR, 32'h5, 1'b0, 0);
      wait_rptr(5);
      cur = 5;
      check(ent_valid_o, 1'b1);
      wb(1'b1, A_QCTL, 32'h3, 1'b0, 0);
      check(ent_valid_o, 1'b0);
      wb(1'b1, A_QCTL, 32'h1, 1'b0, 0);
      repeat (3) @(posedge mclk_i);
      check(ent_valid_o, 1'b0);
      rdy_en <= 1'b1;
      $display("test flush done");
      // transmit error takes the channel out of service
      @(posedge mclk_i);
      tx_err_i      <= 1'b1;
      tx_err_chan_i <= 8'h05;
      @(posedge mclk_i);
      tx_err_i <= 1'b0;
      #1;
      check(abort_o, 1'b1);
      check(abort_chan_o, 8'h05);
      @(posedge mclk_i);
      #1;
      check(chan_enable_o[5], 1'b0);
      $display("test error done");
      stop_test();
   end
endmodule // tb_top

`default_nettype wire
